// ==== rtl/wsm_cfg.svh ====
// constants for the wake-up source monitor
`ifndef WSM_CFG_SVH
`define WSM_CFG_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define WSM_OFS_CTRL 8'h00
`define WSM_OFS_SLEEP_EN 8'h04
`define WSM_OFS_ULP_EN 8'h08
`define WSM_OFS_TIMER 8'h0C
`define WSM_OFS_STATUS 8'h10
`define WSM_OFS_IRQ_STAT 8'h14
`define WSM_OFS_IRQ_MASK 8'h18
`define WSM_OFS_CAUSE 8'h1C

// ---------------------------------------------------------------
// field layout
// ---------------------------------------------------------------
`define WSM_CMD_SLEEP 2'h1
`define WSM_CMD_ULP 2'h2
`define WSM_NPIN 7
`define WSM_PIN_G36 2
`define WSM_PIN_G38 3
`define WSM_PIN_CARD 6
`define WSM_UEN_TIMER 0
`define WSM_UEN_G36 1
`define WSM_UEN_G38 2
`define WSM_UEN_CONV2 3
`define WSM_UEN_CONV3 4
`define WSM_IRQ_SLEEP 0
`define WSM_IRQ_ULP 1
`define WSM_IRQ_INS 2
`define WSM_IRQ_REM 3
`define WSM_TMR_W 16
`define WSM_TICK_W 16

// ---------------------------------------------------------------
// reset values and the always-watched pin mask
// ---------------------------------------------------------------
`define WSM_RST_EN5 5'h00
`define WSM_RST_TIMER 16'h0000
`define WSM_RST_IRQ 4'h0
`define WSM_RST_CAUSE 12'h000
`define WSM_ALWAYS_MON 2'h3

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define WSM_CLK_NS 20
`define WSM_TICK_NS 1000000

`endif

// ==== rtl/wsm_pkg.sv ====
// types for the wake-up source monitor
package wsm_pkg;

    // -----------------------------------------------------------
    // power states
    // -----------------------------------------------------------
    typedef enum logic [2:0] {
        WSM_ACTIVE = 3'h1,
        WSM_SLEEP = 3'h2,
        WSM_ULP = 3'h4
    } wsm_state_t;

endpackage

// ==== rtl/wsm_top.sv ====
// wake-up source monitor with apb register file
//
// Behaviour
// - presence detect carries an internal pull-up, so it reads high unless driven low.
// - in sleep the wake pins are general pins 2, 21, 36, 38, 42, terminal ready and presence detect.
// - a monitored pin wakes the block from sleep on a rising or a falling transition.
// - wake-hold, usb suspend, terminal ready activity or a modem message also end sleep.
// - a general pin wakes the block only once its wake enable has been set.
// - in ultra-low-power state the sleep wake pins are ignored; only configured triggers and power-on wake.
// - ultra-low-power sources are timer, pins 36 and 38, converters 2 and 3, plus power-on.
// - ultra-low-power sources other than pins 36 and 38 have no wake effect in sleep.
// - every general pin is configured with no internal pull-up.
`timescale 1ns/1ps
`include "wsm_cfg.svh"

module wsm_top #(
    parameter int ADDR_W = 8,
    parameter int TICK_CYCLES = `WSM_TICK_NS / `WSM_CLK_NS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // wake pins
    input wire logic general_pin_2,
    input wire logic general_pin_21,
    input wire logic general_pin_36,
    input wire logic general_pin_38,
    input wire logic general_pin_42,
    input wire logic terminal_ready_line,
    input wire logic card_presence_detect,
    // internal and ultra-low-power sources
    input wire logic wake_hold_req,
    input wire logic usb_suspend_evt,
    input wire logic modem_message_exchange,
    input wire logic converter_input_2,
    input wire logic converter_input_3,
    input wire logic power_on_n,
    // pad configuration
    output logic card_detect_pullup_en,
    output logic [4:0] general_pin_pullup_en,
    // power state and interrupt
    output logic in_sleep,
    output logic in_ultra_low_power_state,
    output logic wake_pulse,
    output logic irq
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [`WSM_NPIN-1:0] sync1;
        logic [`WSM_NPIN-1:0] sync2;
        logic [`WSM_NPIN-1:0] prev;
        wsm_pkg::wsm_state_t state;
        logic [4:0] sleep_en;
        logic [4:0] ulp_en;
        logic [`WSM_TMR_W-1:0] timer_reload;
        logic [`WSM_TMR_W-1:0] timer_cnt;
        logic [`WSM_TICK_W-1:0] tick_cnt;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [11:0] cause;
        logic [31:0] rdata;
        logic wake;
        logic card_pu;
        logic [4:0] gpio_pu;
    } wsm_regs_t;

    localparam logic [`WSM_TICK_W-1:0] TICK_LAST = `WSM_TICK_W'(TICK_CYCLES - 1);

    wsm_regs_t r;
    wsm_regs_t next_r;
    logic [`WSM_NPIN-1:0] pins;
    logic [`WSM_NPIN-1:0] pin_change;
    logic [`WSM_NPIN-1:0] sleep_mask;
    logic [`WSM_NPIN-1:0] sleep_hits;
    logic [4:0] ulp_hits;
    logic [2:0] int_hits;
    logic tick;
    logic timer_done;
    logic sleep_wake;
    logic ulp_wake;
    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic [31:0] rd_mux;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;

    assign pins = {card_presence_detect, terminal_ready_line, general_pin_42,
        general_pin_38, general_pin_36, general_pin_21, general_pin_2};

    // ---------------------------------------------------------------
    // per-pin change detection
    // ---------------------------------------------------------------
    // only the second stage and the held sample are compared
    genvar gi;
    generate
        for (gi = 0; gi < `WSM_NPIN; gi++)
        begin : g_pin
            assign pin_change[gi] = r.sync2[gi] ^ r.prev[gi];
        end
    endgenerate

    // ---------------------------------------------------------------
    // wake decisions
    // ---------------------------------------------------------------
    // terminal ready and presence detect are always watched
    assign sleep_mask = {`WSM_ALWAYS_MON, r.sleep_en};
    assign sleep_hits = pin_change & sleep_mask;
    assign int_hits = {modem_message_exchange, usb_suspend_evt, wake_hold_req};
    assign sleep_wake = (r.state == wsm_pkg::WSM_SLEEP) && ((|sleep_hits) || (|int_hits));

    assign tick = (r.tick_cnt == TICK_LAST);
    assign timer_done = (r.timer_cnt == '0);

    // pins 36/38 count here only by their own ultra-low-power enable
    assign ulp_hits[`WSM_UEN_TIMER] = timer_done & r.ulp_en[`WSM_UEN_TIMER];
    assign ulp_hits[`WSM_UEN_G36] = pin_change[`WSM_PIN_G36] & r.ulp_en[`WSM_UEN_G36];
    assign ulp_hits[`WSM_UEN_G38] = pin_change[`WSM_PIN_G38] & r.ulp_en[`WSM_UEN_G38];
    assign ulp_hits[`WSM_UEN_CONV2] = converter_input_2 & r.ulp_en[`WSM_UEN_CONV2];
    assign ulp_hits[`WSM_UEN_CONV3] = converter_input_3 & r.ulp_en[`WSM_UEN_CONV3];
    // power-on is low active and always enabled
    assign ulp_wake = (r.state == wsm_pkg::WSM_ULP)
        && ((|ulp_hits) || !power_on_n);

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    // zero wait states: data is captured in the setup cycle
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;

    always_comb
    begin
        addr_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `WSM_OFS_CTRL:
            begin
                rd_mux = 32'h0000_0000;
            end
            `WSM_OFS_SLEEP_EN:
            begin
                rd_mux = {27'h000_0000, r.sleep_en};
            end
            `WSM_OFS_ULP_EN:
            begin
                rd_mux = {27'h000_0000, r.ulp_en};
            end
            `WSM_OFS_TIMER:
            begin
                rd_mux = {r.timer_cnt, r.timer_reload};
            end
            `WSM_OFS_STATUS:
            begin
                rd_mux = {21'h00_0000, r.sync2, 1'b0, r.state};
            end
            `WSM_OFS_IRQ_STAT:
            begin
                rd_mux = {28'h000_0000, r.irq_stat};
            end
            `WSM_OFS_IRQ_MASK:
            begin
                rd_mux = {28'h000_0000, r.irq_mask};
            end
            `WSM_OFS_CAUSE:
            begin
                rd_mux = {20'h0_0000, r.cause};
            end
            default:
            begin
                addr_ok = 1'b0;
            end
        endcase
    end

    assign pslverr = psel && penable && !addr_ok;

    // ---------------------------------------------------------------
    // interrupt events
    // ---------------------------------------------------------------
    always_comb
    begin
        irq_set = 4'h0;
        irq_set[`WSM_IRQ_SLEEP] = sleep_wake;
        irq_set[`WSM_IRQ_ULP] = ulp_wake;
        irq_set[`WSM_IRQ_INS] = pin_change[`WSM_PIN_CARD] & r.sync2[`WSM_PIN_CARD];
        irq_set[`WSM_IRQ_REM] = pin_change[`WSM_PIN_CARD] & !r.sync2[`WSM_PIN_CARD];
        irq_clr = 4'h0;
        if (wr_en && paddr == `WSM_OFS_IRQ_STAT)
        begin
            irq_clr = pwdata[3:0];
        end
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.sync1 = pins;
        next_r.sync2 = r.sync1;
        next_r.prev = r.sync2;
        next_r.wake = 1'b0;
        next_r.card_pu = 1'b1;
        next_r.gpio_pu = 5'h00;
        // set wins over a clear in the same cycle
        next_r.irq_stat = (r.irq_stat & ~irq_clr) | irq_set;
        if (rd_setup)
        begin
            next_r.rdata = rd_mux;
        end
        if (r.state == wsm_pkg::WSM_ULP)
        begin
            next_r.tick_cnt = tick ? '0 : r.tick_cnt + 1'b1;
            if (tick && !timer_done)
            begin
                next_r.timer_cnt = r.timer_cnt - 1'b1;
            end
        end
        if (wr_en)
        begin
            case (paddr)
                `WSM_OFS_SLEEP_EN:
                begin
                    next_r.sleep_en = pwdata[4:0];
                end
                `WSM_OFS_ULP_EN:
                begin
                    next_r.ulp_en = pwdata[4:0];
                end
                `WSM_OFS_TIMER:
                begin
                    next_r.timer_reload = pwdata[`WSM_TMR_W-1:0];
                end
                `WSM_OFS_IRQ_MASK:
                begin
                    next_r.irq_mask = pwdata[3:0];
                end
                default:
                begin
                    next_r.irq_mask = r.irq_mask;
                end
            endcase
        end
        case (r.state)
            wsm_pkg::WSM_ACTIVE:
            begin
                // entry commands are honoured only while active
                if (wr_en && paddr == `WSM_OFS_CTRL)
                begin
                    if (pwdata[1:0] == `WSM_CMD_SLEEP)
                    begin
                        next_r.state = wsm_pkg::WSM_SLEEP;
                    end
                    else if (pwdata[1:0] == `WSM_CMD_ULP)
                    begin
                        next_r.state = wsm_pkg::WSM_ULP;
                        next_r.timer_cnt = r.timer_reload;
                        next_r.tick_cnt = '0;
                    end
                end
            end
            wsm_pkg::WSM_SLEEP:
            begin
                if (sleep_wake)
                begin
                    next_r.state = wsm_pkg::WSM_ACTIVE;
                    next_r.wake = 1'b1;
                    next_r.cause = {2'h0, int_hits, sleep_hits};
                end
            end
            wsm_pkg::WSM_ULP:
            begin
                if (ulp_wake)
                begin
                    next_r.state = wsm_pkg::WSM_ACTIVE;
                    next_r.wake = 1'b1;
                    next_r.cause = {1'b1, !power_on_n, 5'h00, ulp_hits};
                end
            end
            default:
            begin
                next_r.state = wsm_pkg::WSM_ACTIVE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r.sync1 <= '0;
            r.sync2 <= '0;
            r.prev <= '0;
            r.state <= wsm_pkg::WSM_ACTIVE;
            r.sleep_en <= `WSM_RST_EN5;
            r.ulp_en <= `WSM_RST_EN5;
            r.timer_reload <= `WSM_RST_TIMER;
            r.timer_cnt <= `WSM_RST_TIMER;
            r.tick_cnt <= '0;
            r.irq_stat <= `WSM_RST_IRQ;
            r.irq_mask <= `WSM_RST_IRQ;
            r.cause <= `WSM_RST_CAUSE;
            r.rdata <= 32'h0000_0000;
            r.wake <= 1'b0;
            r.card_pu <= 1'b1;
            r.gpio_pu <= 5'h00;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign prdata = r.rdata;
    assign card_detect_pullup_en = r.card_pu;
    assign general_pin_pullup_en = r.gpio_pu;
    assign in_sleep = (r.state == wsm_pkg::WSM_SLEEP);
    assign in_ultra_low_power_state = (r.state == wsm_pkg::WSM_ULP);
    assign wake_pulse = r.wake;
    assign irq = |(r.irq_stat & r.irq_mask);

endmodule

// ==== verif/wsm_card_holder.sv ====
// card holder model driving the presence detect line
`timescale 1ns/1ps
module wsm_card_holder (
    // card placed by the bench
    input wire logic card_in,
    // line toward the block
    output logic card_presence_detect
);
    // empty holder grounds the line; a card drives it high
    assign card_presence_detect = card_in ? 1'b1 : 1'b0;
endmodule

// ==== verif/wsm_top_asserts.sv ====
// port checker for the wake-up source monitor
`timescale 1ns/1ps
module wsm_top_asserts (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // sources
    input wire logic wake_hold_req,
    input wire logic usb_suspend_evt,
    input wire logic modem_message_exchange,
    input wire logic power_on_n,
    // outputs
    input wire logic card_detect_pullup_en,
    input wire logic [4:0] general_pin_pullup_en,
    input wire logic in_sleep,
    input wire logic in_ultra_low_power_state,
    input wire logic wake_pulse
);
    logic int_req;
    assign int_req = wake_hold_req | usb_suspend_evt | modem_message_exchange;
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_woke;
        !in_sleep && wake_pulse;
    endsequence
    sequence s_left_low;
        !in_ultra_low_power_state && wake_pulse;
    endsequence
    property p_pulse_cause;
        wake_pulse |-> $past(in_sleep) || $past(in_ultra_low_power_state);
    endproperty
    property p_power_on;
        in_ultra_low_power_state && !power_on_n |=> s_left_low;
    endproperty
    AST_CARD_PULLUP: assert property (card_detect_pullup_en == 1'b1)
        else $error("card detect pull-up off");
    AST_PIN_NO_PULL: assert property (general_pin_pullup_en == 5'h00)
        else $error("general pin pull-up on");
    AST_PULSE_ONE: assert property (wake_pulse |=> !wake_pulse)
        else $error("wake pulse longer than one cycle");
    AST_PULSE_CAUSE: assert property (p_pulse_cause)
        else $error("wake pulse without low-power state");
    AST_SLEEP_EXIT: assert property ($fell(in_sleep) |-> s_woke)
        else $error("sleep left without wake pulse");
    AST_ULP_EXIT: assert property ($fell(in_ultra_low_power_state) |-> s_left_low)
        else $error("low-power state left without wake pulse");
    AST_INT_WAKE: assert property (in_sleep && int_req |=> s_woke)
        else $error("internal source did not end sleep");
    AST_POWER_ON: assert property (p_power_on)
        else $error("power-on did not end low-power state");
endmodule
bind wsm_top wsm_top_asserts i_wsm_top_asserts (.pclk, .presetn, .wake_hold_req,
    .usb_suspend_evt, .modem_message_exchange, .power_on_n, .card_detect_pullup_en,
    .general_pin_pullup_en, .in_sleep, .in_ultra_low_power_state, .wake_pulse);

// ==== verif/tb.sv ====
// self-checking bench for the wake-up source monitor
`timescale 1ns/1ps
`include "wsm_cfg.svh"
module tb;
    // ------
    // signals
    // ------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] pin = 6'h00;
    logic card_in = 1'b0;
    logic card;
    logic hold = 1'b0;
    logic usb = 1'b0;
    logic modem = 1'b0;
    logic cv2 = 1'b0;
    logic cv3 = 1'b0;
    logic pwr_n = 1'b1;
    logic pull_card;
    logic [4:0] pull_pins;
    logic slp;
    logic ulp;
    logic wp;
    logic irq;
    logic err;
    logic [31:0] rd;
    int n_mismatch = 0;
    int n_tests = 0;
    always #10 pclk = ~pclk;
    wsm_card_holder i_wsm_card_holder (.card_in(card_in), .card_presence_detect(card));
    // short tick keeps the timer wake within a few cycles
    wsm_top #(.TICK_CYCLES(4)) i_wsm_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .general_pin_2(pin[0]), .general_pin_21(pin[1]),
        .general_pin_36(pin[2]), .general_pin_38(pin[3]), .general_pin_42(pin[4]),
        .terminal_ready_line(pin[5]), .card_presence_detect(card), .wake_hold_req(hold),
        .usb_suspend_evt(usb), .modem_message_exchange(modem), .converter_input_2(cv2),
        .converter_input_3(cv3), .power_on_n(pwr_n), .card_detect_pullup_en(pull_card),
        .general_pin_pullup_en(pull_pins), .in_sleep(slp), .in_ultra_low_power_state(ulp),
        .wake_pulse(wp), .irq(irq));
    // ------
    // tasks
    // ------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ctrl(input logic [1:0] cmd);
        apb(1'b1, `WSM_OFS_CTRL, {30'h0, cmd});
    endtask
    task automatic wake(input string what);
        int i;
        for (i = 0; i < 40 && wp !== 1'b1; i++)
            @(posedge pclk);
        chk(what, 32'(wp), 32'h1);
    endtask
    task automatic end_sim();
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic t_reset();
        chk("card pull-up", 32'(pull_card), 32'h1);
        chk("pin pull-ups", 32'(pull_pins), 32'h0);
        apb(1'b0, `WSM_OFS_SLEEP_EN, 32'h0);
        chk("sleep enables", rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", 32'(err), 32'h1);
        apb(1'b1, `WSM_OFS_IRQ_STAT, 32'hF);
    endtask
    task automatic t_sleep_pins();
        int i;
        apb(1'b1, `WSM_OFS_SLEEP_EN, 32'h1F);
        apb(1'b1, `WSM_OFS_IRQ_MASK, 32'h1);
        for (i = 0; i < 14; i++)
        begin
            ctrl(`WSM_CMD_SLEEP);
            repeat (6) @(posedge pclk);
            chk("sleep", 32'(slp), 32'h1);
            if (i % 7 == 6)
                card_in <= ~card_in;
            else
                pin[i % 7] <= ~pin[i % 7];
            wake("pin wake");
            chk("irq set", 32'(irq), 32'h1);
            apb(1'b0, `WSM_OFS_CAUSE, 32'h0);
            chk("pin cause", rd & 32'h7F, 32'h1 << (i % 7));
            apb(1'b0, `WSM_OFS_IRQ_STAT, 32'h0);
            chk("irq status", rd, (i == 6) ? 32'h5 : (i == 13) ? 32'h9 : 32'h1);
            apb(1'b1, `WSM_OFS_IRQ_STAT, 32'hF);
            @(posedge pclk);
            chk("irq clear", 32'(irq), 32'h0);
        end
    endtask
    task automatic t_sleep_other();
        int k;
        apb(1'b1, `WSM_OFS_SLEEP_EN, 32'h0);
        apb(1'b1, `WSM_OFS_ULP_EN, 32'h1F);
        for (k = 0; k < 3; k++)
        begin
            ctrl(`WSM_CMD_SLEEP);
            // pin 36 is enabled for low power only, so sleep must ignore it
            pin[2] <= ~pin[2];
            cv2 <= 1'b1;
            pwr_n <= 1'b0;
            repeat (12) @(posedge pclk);
            chk("sleep kept", 32'(slp), 32'h1);
            cv2 <= 1'b0;
            pwr_n <= 1'b1;
            hold <= (k == 0);
            usb <= (k == 1);
            modem <= (k == 2);
            wake("internal wake");
            hold <= 1'b0;
            usb <= 1'b0;
            modem <= 1'b0;
            apb(1'b0, `WSM_OFS_CAUSE, 32'h0);
            chk("internal cause", rd, 32'h80 << k);
        end
    endtask
    task automatic t_ulp();
        int k;
        apb(1'b1, `WSM_OFS_IRQ_MASK, 32'h0);
        apb(1'b1, `WSM_OFS_ULP_EN, 32'h0);
        apb(1'b1, `WSM_OFS_TIMER, 32'h2);
        ctrl(`WSM_CMD_ULP);
        pin <= ~pin;
        hold <= 1'b1;
        repeat (30) @(posedge pclk);
        chk("low-power kept", 32'(ulp), 32'h1);
        hold <= 1'b0;
        pwr_n <= 1'b0;
        wake("power-on wake");
        pwr_n <= 1'b1;
        chk("masked irq", 32'(irq), 32'h0);
        apb(1'b0, `WSM_OFS_CAUSE, 32'h0);
        chk("power-on cause", rd, 32'hC00);
        for (k = 0; k < 5; k++)
        begin
            apb(1'b1, `WSM_OFS_ULP_EN, 32'h1 << k);
            ctrl(`WSM_CMD_ULP);
            if (k == 1 || k == 2)
                pin[k + 1] <= ~pin[k + 1];
            cv2 <= (k == 3);
            cv3 <= (k == 4);
            wake("low-power wake");
            cv2 <= 1'b0;
            cv3 <= 1'b0;
            apb(1'b0, `WSM_OFS_CAUSE, 32'h0);
            chk("low-power cause", rd, 32'h800 | (32'h1 << k));
        end
    endtask
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        t_reset();
        t_sleep_pins();
        t_sleep_other();
        t_ulp();
        end_sim();
    end
    // roughly twenty times the expected run
    initial
    begin
        #200000;
        n_mismatch++;
        end_sim();
    end
endmodule
